// ==== design/port_power_oc_ctl.sv ====
// Purpose: Power enable / overcurrent sense control for six downstream ports
// Assumes: Pins are shared: pull-up input when on, driven low when off
// Notes:   Pins arrive asynchronously and are synchronised before use
`default_nettype none

module port_power_oc_ctl
    import port_power_pkg::*;
#(
    parameter int BLANK_CYCLES = OC_BLANK_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    // Register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    output logic                   irq,
    // Shared power / overcurrent pins, input side
    input  wire logic              port1_power_oc_pin_in,
    input  wire logic              port2_power_oc_pin_in,
    input  wire logic              port3_power_oc_pin_in,
    input  wire logic              port4_power_oc_pin_in,
    input  wire logic              port5_power_oc_pin_in,
    input  wire logic              port6_power_oc_pin_in,
    // Shared power / overcurrent pins, drive side
    output pin_ctl_s               port1_power_oc_pin,
    output pin_ctl_s               port2_power_oc_pin,
    output pin_ctl_s               port3_power_oc_pin,
    output pin_ctl_s               port4_power_oc_pin,
    output pin_ctl_s               port5_power_oc_pin,
    output pin_ctl_s               port6_power_oc_pin,
    // Superspeed portion enables for split ports
    output logic                   port3_superspeed_enable,
    output logic                   port4_superspeed_enable,
    output logic                   port5_superspeed_enable,
    // Reports to hub control logic
    output logic      [NPORTS-1:0] oc_event,
    output logic      [NPORTS-1:0] oc_usb2,
    output logic      [NPORTS-1:0] oc_usb3
);

    // ==================================================================
    // Local sizes
    localparam int BW = $clog2(BLANK_CYCLES + 1);
    localparam logic [BW-1:0] BLANK_LOAD = BW'(BLANK_CYCLES);

    // ==================================================================
    // Helpers

    // Places a port-wide field at its bit position in a read word
    function automatic logic [DATA_W-1:0] place(
        input logic [NPORTS-1:0] val,
        input int                lsb
    );
        logic [DATA_W-1:0] w;
        w = '0;
        w[lsb +: NPORTS] = val;
        return w;
    endfunction : place

    // Write strobe for one register offset
    function automatic logic hit(
        input logic              strobe,
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] offset
    );
        return strobe && (a == offset);
    endfunction : hit

    // ==================================================================
    // Software-visible state
    logic [NPORTS-1:0] cfg_enable;
    logic [NPORTS-1:0] next_cfg_enable;

    logic              split_port_mode;
    logic              next_split_port_mode;

    logic [NPORTS-1:0] host_power;
    logic [NPORTS-1:0] next_host_power;

    logic [SS_NUM-1:0] ss_enable;
    logic [SS_NUM-1:0] next_ss_enable;

    logic [NPORTS-1:0] int_status;
    logic [NPORTS-1:0] next_int_status;

    logic [NPORTS-1:0] int_mask;
    logic [NPORTS-1:0] next_int_mask;

    logic [DATA_W-1:0] next_rdata;
    logic              next_irq;

    // ==================================================================
    // Port state
    logic [NPORTS-1:0] port_on;

    logic [NPORTS-1:0] pin_on;
    logic [NPORTS-1:0] next_pin_on;

    logic [NPORTS-1:0] pin_raw;
    logic [NPORTS-1:0] pin_sync;

    logic [NPORTS-1:0] oc_level;
    logic [NPORTS-1:0] next_oc_level;

    logic [NPORTS-1:0] next_oc_event;
    logic [NPORTS-1:0] next_oc_usb2;
    logic [NPORTS-1:0] next_oc_usb3;

    logic [SS_NUM-1:0] ss_out;
    logic [SS_NUM-1:0] next_ss_out;

    pin_ctl_s          pin_drv      [NPORTS];
    pin_ctl_s          next_pin_drv [NPORTS];

    // ==================================================================
    // Pin gathering, one pin per port in port order

    assign pin_raw = {port6_power_oc_pin_in,
                      port5_power_oc_pin_in,
                      port4_power_oc_pin_in,
                      port3_power_oc_pin_in,
                      port2_power_oc_pin_in,
                      port1_power_oc_pin_in};

    // Idle-high init keeps a floating or disabled pin from reading as fault
    level_sync #(
        .WIDTH (NPORTS),
        .INIT  ({NPORTS{1'b1}})
    ) u_pin_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (pin_raw),
        .sync_out (pin_sync)
    );

    // A port is on only when configuration and host both allow it
    assign port_on = cfg_enable & host_power;

    // ==================================================================
    // Register file: next values
    always_comb begin
        next_cfg_enable      = cfg_enable;
        next_split_port_mode = split_port_mode;
        next_host_power      = host_power;
        next_ss_enable       = ss_enable;
        next_int_mask        = int_mask;
        next_int_status      = int_status;
        next_rdata           = '0;

        if (hit(wr, addr, REG_CTRL)) begin
            next_cfg_enable      = wdata[CTRL_ENABLE_LSB +: NPORTS];
            next_split_port_mode = wdata[CTRL_SPLIT_BIT];
        end

        if (hit(wr, addr, REG_HOST_POWER)) begin
            next_host_power = wdata[NPORTS-1:0];
        end

        if (hit(wr, addr, REG_SS_ENABLE)) begin
            next_ss_enable = wdata[SS_NUM-1:0];
        end

        if (hit(wr, addr, REG_INT_MASK)) begin
            next_int_mask = wdata[NPORTS-1:0];
        end

        if (hit(wr, addr, REG_INT_STATUS)) begin
            next_int_status = int_status & ~wdata[NPORTS-1:0];
        end
        // A new event in the clearing cycle stays set
        next_int_status = next_int_status | next_oc_event;

        if (rd) begin
            unique case (addr)
                REG_CTRL: begin
                    next_rdata = place(cfg_enable, CTRL_ENABLE_LSB);
                    next_rdata[CTRL_SPLIT_BIT] = split_port_mode;
                end

                REG_HOST_POWER: begin
                    next_rdata = place(host_power, 0);
                end

                REG_SS_ENABLE: begin
                    next_rdata = DATA_W'(ss_enable);
                end

                REG_STATUS: begin
                    next_rdata = place(pin_on, STAT_ON_LSB)
                               | place(oc_level, STAT_OC_LSB);
                end

                REG_INT_STATUS: begin
                    next_rdata = place(int_status, 0);
                end

                REG_INT_MASK: begin
                    next_rdata = place(int_mask, 0);
                end

                default: begin
                    next_rdata = '0;
                end
            endcase
        end

        next_irq = |(next_int_status & next_int_mask);
    end

    // ==================================================================
    // Register file: state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_enable      <= CFG_ENABLE_RST;
            split_port_mode <= SPLIT_RST;
            host_power      <= HOST_POWER_RST;
            ss_enable       <= SS_ENABLE_RST;
            int_status      <= '0;
            int_mask        <= INT_MASK_RST;
            rdata           <= '0;
            irq             <= 1'b0;
        end else begin
            cfg_enable      <= next_cfg_enable;
            split_port_mode <= next_split_port_mode;
            host_power      <= next_host_power;
            ss_enable       <= next_ss_enable;
            int_status      <= next_int_status;
            int_mask        <= next_int_mask;
            rdata           <= next_rdata;
            irq             <= next_irq;
        end
    end

    // ==================================================================
    // Per-port pin control and overcurrent sensing
    generate
        for (genvar p = 0; p < NPORTS; p++) begin : g_port
            logic [BW-1:0] blank;
            logic [BW-1:0] next_blank;
            logic          sensing;

            // The pull-up needs time to lift the pin after power-on,
            // so a low level is ignored until the blanking window ends
            assign sensing = pin_on[p] && (blank == '0);

            always_comb begin
                next_pin_on[p] = port_on[p];

                // Reload while off, so every power-on is blanked
                if (!pin_on[p]) begin
                    next_blank = BLANK_LOAD;
                end else if (blank != '0) begin
                    next_blank = blank - BW'(1);
                end else begin
                    next_blank = blank;
                end

                if (port_on[p]) begin
                    next_pin_drv[p].pull_up = 1'b1;
                    next_pin_drv[p].oe_n    = 1'b1;
                    next_pin_drv[p].out     = 1'b0;
                end else begin
                    next_pin_drv[p].pull_up = 1'b0;
                    next_pin_drv[p].oe_n    = 1'b0;
                    next_pin_drv[p].out     = 1'b0;
                end

                // Low level on a powered, settled pin is overcurrent
                next_oc_level[p] = sensing && port_on[p] && !pin_sync[p];
                next_oc_event[p] = next_oc_level[p] && !oc_level[p];
                next_oc_usb2[p]  = next_oc_level[p];

                // Superspeed portion follows the pin unless split away
                if (SPLIT_CAPABLE[p]) begin
                    next_oc_usb3[p] = next_oc_level[p] && !split_port_mode;
                end else begin
                    next_oc_usb3[p] = next_oc_level[p];
                end
            end

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    blank      <= BLANK_LOAD;
                    pin_on[p]  <= 1'b0;
                    pin_drv[p] <= '{pull_up: 1'b0, oe_n: 1'b0, out: 1'b0};
                    oc_level[p] <= 1'b0;
                    oc_event[p] <= 1'b0;
                    oc_usb2[p]  <= 1'b0;
                    oc_usb3[p]  <= 1'b0;
                end else begin
                    blank       <= next_blank;
                    pin_on[p]   <= next_pin_on[p];
                    pin_drv[p]  <= next_pin_drv[p];
                    oc_level[p] <= next_oc_level[p];
                    oc_event[p] <= next_oc_event[p];
                    oc_usb2[p]  <= next_oc_usb2[p];
                    oc_usb3[p]  <= next_oc_usb3[p];
                end
            end
        end
    endgenerate

    // ==================================================================
    // Superspeed enables for ports 3 to 5 of the split-capable ports 1 to 5
    generate
        for (genvar s = 0; s < SS_NUM; s++) begin : g_ss
            // Held low with split off, so a board may leave it unused
            always_comb begin
                next_ss_out[s] = split_port_mode && ss_enable[s];
            end

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    ss_out[s] <= 1'b0;
                end else begin
                    ss_out[s] <= next_ss_out[s];
                end
            end
        end
    endgenerate

    // ==================================================================
    // Outputs, all taken from registers above

    assign port1_power_oc_pin = pin_drv[0];
    assign port2_power_oc_pin = pin_drv[1];
    assign port3_power_oc_pin = pin_drv[2];
    assign port4_power_oc_pin = pin_drv[3];
    assign port5_power_oc_pin = pin_drv[4];
    assign port6_power_oc_pin = pin_drv[5];

    assign port3_superspeed_enable = ss_out[0];
    assign port4_superspeed_enable = ss_out[1];
    assign port5_superspeed_enable = ss_out[2];

    // Floating a pin is safe only while its port stays disabled: the
    // driven-low output then defines the net and sensing is off

endmodule : port_power_oc_ctl

`default_nettype wire

// ==== inc/port_power_pkg.sv ====
// Purpose: Shared constants and types for downstream port power / overcurrent control
// Assumes: 100 MHz core clock, six downstream ports, plain register port
`default_nettype none

package port_power_pkg;

    // ==================================================================
    // Sizes
    localparam int NPORTS    = 6;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int SS_FIRST  = 2;
    localparam int SS_NUM    = 3;

    // ==================================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] REG_HOST_POWER = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SS_ENABLE  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_INT_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] REG_INT_MASK   = 8'h14;

    // ==================================================================
    // Field positions
    localparam int CTRL_ENABLE_LSB = 0;
    localparam int CTRL_SPLIT_BIT  = 8;
    localparam int STAT_ON_LSB     = 0;
    localparam int STAT_OC_LSB     = 8;

    // ==================================================================
    // Reset values
    localparam logic [NPORTS-1:0] CFG_ENABLE_RST = 6'h3f;
    localparam logic              SPLIT_RST      = 1'h0;
    localparam logic [NPORTS-1:0] HOST_POWER_RST = 6'h00;
    localparam logic [SS_NUM-1:0] SS_ENABLE_RST  = 3'h0;
    localparam logic [NPORTS-1:0] INT_MASK_RST   = 6'h00;

    // Ports whose pin follows the split setting; port 6 never does
    localparam logic [NPORTS-1:0] SPLIT_CAPABLE  = 6'h1f;

    // ==================================================================
    // Timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int OC_BLANK_NS     = 1000;
    localparam int OC_BLANK_CYCLES = (OC_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==================================================================
    // Pin drive carrier: oe_n low while the block drives the pin
    typedef struct packed {
        logic pull_up;
        logic oe_n;
        logic out;
    } pin_ctl_s;

endpackage : port_power_pkg

`default_nettype wire

// ==== design/level_sync.sv ====
// Purpose: Two-stage synchroniser for a bundle of slow levels
// Assumes: Each bit is an independent level; no bus coherency needed
// Notes:   First stage feeds only the second stage
`default_nettype none

module level_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '1
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta     <= INIT;
            sync_out <= INIT;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : level_sync

`default_nettype wire

// ==== tb/port_power_oc_ctl_checker.sv ====
// Purpose: Port-level assertions for port_power_oc_ctl
// Assumes: One clock domain; sees top ports only
// Notes:   Lane n of each six-lane vector is port n+1; lane n of ss is port n+3
`default_nettype none

module port_power_oc_ctl_checker
    import port_power_pkg::*;
#(
    parameter int BLANK_CYCLES = OC_BLANK_CYCLES
) (
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              wr,
    input wire logic              port1_power_oc_pin_in,
    input wire logic              port2_power_oc_pin_in,
    input wire logic              port3_power_oc_pin_in,
    input wire logic              port4_power_oc_pin_in,
    input wire logic              port5_power_oc_pin_in,
    input wire logic              port6_power_oc_pin_in,
    input wire pin_ctl_s          port1_power_oc_pin,
    input wire pin_ctl_s          port2_power_oc_pin,
    input wire pin_ctl_s          port3_power_oc_pin,
    input wire pin_ctl_s          port4_power_oc_pin,
    input wire pin_ctl_s          port5_power_oc_pin,
    input wire pin_ctl_s          port6_power_oc_pin,
    input wire logic              port3_superspeed_enable,
    input wire logic              port4_superspeed_enable,
    input wire logic              port5_superspeed_enable,
    input wire logic [NPORTS-1:0] oc_event,
    input wire logic [NPORTS-1:0] oc_usb2,
    input wire logic [NPORTS-1:0] oc_usb3
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================================================
    // Lanes
    pin_ctl_s          pins [NPORTS];
    logic [NPORTS-1:0] pu;
    logic [NPORTS-1:0] oen;
    logic [NPORTS-1:0] dout;
    logic [NPORTS-1:0] lvl;
    logic [2:0]        ss;

    assign pins = '{port1_power_oc_pin, port2_power_oc_pin, port3_power_oc_pin,
                    port4_power_oc_pin, port5_power_oc_pin, port6_power_oc_pin};
    assign lvl = {port6_power_oc_pin_in, port5_power_oc_pin_in, port4_power_oc_pin_in,
                  port3_power_oc_pin_in, port2_power_oc_pin_in, port1_power_oc_pin_in};
    assign ss = {port5_superspeed_enable, port4_superspeed_enable, port3_superspeed_enable};

    always_comb begin
        for (int k = 0; k < NPORTS; k++) begin
            pu[k]   = pins[k].pull_up;
            oen[k]  = pins[k].oe_n;
            dout[k] = pins[k].out;
        end
    end

    // ====================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_oc_rise;
        (oc_usb2 & ~$past(oc_usb2)) != 6'h00;
    endsequence

    // A new overcurrent lane needs its pin low two edges earlier (synchroniser depth)
    property p_oc_cause; s_oc_rise |-> (oc_usb2 & ~$past(oc_usb2) & $past(lvl, 2)) == 6'h00; endproperty
    property p_event_edge; oc_event == (oc_usb2 & ~$past(oc_usb2)); endproperty
    property p_event_on; (oc_event & ~pu) == 6'h00; endproperty
    property p_pin_shape; pu == oen; endproperty
    property p_pin_low; dout == 6'h00; endproperty
    property p_pin_cause; $changed(oen) |-> $past(wr, 2); endproperty
    property p_usb3_port6; oc_usb3[5] == oc_usb2[5]; endproperty
    property p_usb3_mirror; (oc_usb3[4:0] & ~oc_usb2[4:0]) == 5'h00; endproperty
    property p_split_usb2; (ss != 3'h0) [*3] |-> oc_usb3[4:0] == 5'h00; endproperty
    property p_ss_cause; $changed(ss) |-> $past(wr) || $past(wr, 2); endproperty

    a_oc_cause: assert property (p_oc_cause) else $error("oc without low pin");
    a_event_edge: assert property (p_event_edge) else $error("oc event not edge");
    a_event_on: assert property (p_event_on) else $error("oc event on off port");
    a_pin_shape: assert property (p_pin_shape) else $error("pull-up vs drive");
    a_pin_low: assert property (p_pin_low) else $error("pin driven high");
    a_pin_cause: assert property (p_pin_cause) else $error("pin moved unasked");
    a_usb3_port6: assert property (p_usb3_port6) else $error("port6 portions split");
    a_usb3_mirror: assert property (p_usb3_mirror) else $error("usb3 oc alone");
    a_split_usb2: assert property (p_split_usb2) else $error("usb3 oc in split");
    a_ss_cause: assert property (p_ss_cause) else $error("ss enable unasked");

endmodule : port_power_oc_ctl_checker

`default_nettype wire

// ==== tb/port_power_switch_model.sv ====
// Purpose: External power switches and current monitors on the port pins
// Assumes: Monitors pull low (open drain); a switch is on while its pin is high
// Notes:   An undriven pin without pull-up toggles, so no stale level is read
`default_nettype none

module port_power_switch_model
    import port_power_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [NPORTS-1:0] pull_up,
    input  wire logic [NPORTS-1:0] oe_n,
    input  wire logic [NPORTS-1:0] out,
    input  wire logic [NPORTS-1:0] fault,
    output logic      [NPORTS-1:0] level,
    output logic      [NPORTS-1:0] powered
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NPORTS-1:0] flip = 6'h00;

    always @(posedge clk) begin
        flip <= ~flip;
    end

    always_comb begin
        for (int k = 0; k < NPORTS; k++) begin
            if (!oe_n[k]) begin
                level[k] = out[k];
            end else if (fault[k]) begin
                level[k] = 1'b0;
            end else if (pull_up[k]) begin
                level[k] = 1'b1;
            end else begin
                level[k] = flip[k];
            end
        end
        powered = level;
    end

endmodule : port_power_switch_model

`default_nettype wire

// ==== tb/test_port_power_overcurrent_ctl.sv ====
// Purpose: Self-checking bench for the port power / overcurrent block
// Assumes: Blanking shortened to 2 cycles; pins resolved by the switch model
// Notes:   Expectations come from a small register model kept in the bench
`default_nettype none

module test_port_power_overcurrent_ctl
    import port_power_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BLANK = 2;

    // ====================================================
    // Signals
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [NPORTS-1:0] fault = 6'h00;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    pin_ctl_s          pin [NPORTS];
    logic [NPORTS-1:0] pu, oen, dout, lvl, powered;
    logic [NPORTS-1:0] oc_event, oc_usb2, oc_usb3;
    logic [2:0]        ss;
    logic [NPORTS-1:0] cen = 6'h3f;
    logic [NPORTS-1:0] host = 6'h00;
    logic [NPORTS-1:0] imask;
    logic [7:0]        ra [7] = '{REG_CTRL, REG_HOST_POWER, REG_SS_ENABLE, REG_STATUS,
                                  REG_INT_STATUS, REG_INT_MASK, 8'h18};
    logic [31:0]       rv [7] = '{32'h3f, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    int                n_fail = 0;
    int                comparisons = 0;

    port_power_oc_ctl #(.BLANK_CYCLES(BLANK)) i_dut (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq),
        .port1_power_oc_pin_in(lvl[0]), .port2_power_oc_pin_in(lvl[1]),
        .port3_power_oc_pin_in(lvl[2]), .port4_power_oc_pin_in(lvl[3]),
        .port5_power_oc_pin_in(lvl[4]), .port6_power_oc_pin_in(lvl[5]),
        .port1_power_oc_pin(pin[0]), .port2_power_oc_pin(pin[1]), .port3_power_oc_pin(pin[2]),
        .port4_power_oc_pin(pin[3]), .port5_power_oc_pin(pin[4]), .port6_power_oc_pin(pin[5]),
        .port3_superspeed_enable(ss[0]), .port4_superspeed_enable(ss[1]),
        .port5_superspeed_enable(ss[2]),
        .oc_event(oc_event), .oc_usb2(oc_usb2), .oc_usb3(oc_usb3));

    port_power_switch_model i_sw (.clk(clk), .pull_up(pu), .oe_n(oen), .out(dout),
        .fault(fault), .level(lvl), .powered(powered));

    always_comb begin
        for (int k = 0; k < NPORTS; k++) begin
            pu[k]   = pin[k].pull_up;
            oen[k]  = pin[k].oe_n;
            dout[k] = pin[k].out;
        end
    end

    initial begin
        forever #5 clk = ~clk;
    end

    // ====================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wreg

    task automatic rchk(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, v);
    endtask : rchk

    task automatic check_pins;
        logic [NPORTS-1:0] on;
        on = cen & host;
        repeat (3) @(posedge clk);
        #1;
        for (int k = 0; k < NPORTS; k++) begin
            chk(32'(pin[k]), on[k] ? 32'h6 : 32'h0);
        end
        chk(32'(powered), 32'(on));
        rchk(REG_STATUS, 32'(on));
    endtask : check_pins

    // Overcurrent on one enabled port, with a random interrupt mask
    task automatic oc_hit(input int k, input int s);
        logic [NPORTS-1:0] b;
        b = 6'(1 << k);
        imask = 6'($urandom_range(0, 63));
        wreg(REG_INT_MASK, 32'(imask));
        @(posedge clk);
        fault <= b;
        repeat (3) @(posedge clk);
        #1;
        chk(32'(oc_event), 32'(b));
        chk(32'(oc_usb2), 32'(b));
        chk(32'(oc_usb3), (k == 5 || s == 0) ? 32'(b) : 32'h0);
        @(posedge clk);
        #1;
        chk(32'(irq), 32'((b & imask) != 6'h00));
        rchk(REG_STATUS, (32'(b) << STAT_OC_LSB) | 32'h3f);
        rchk(REG_INT_STATUS, 32'(b));
        @(posedge clk);
        fault <= 6'h00;
        wreg(REG_INT_STATUS, 32'(b));
        repeat (4) @(posedge clk);
        #1;
        chk(32'(irq), 32'h0);
        chk(32'(oc_usb2), 32'h0);
    endtask : oc_hit

    task automatic report_and_stop;
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // ====================================================
    // Sequence
    initial begin
        #500us;
        n_fail++;
        $display("unexpected at %0t: run did not finish", $time);
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h27964c4a));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        // Unmapped and read-only writes must leave everything at reset
        wreg(8'h18, 32'hffffffff);
        wreg(REG_STATUS, 32'hffffffff);
        for (int i = 0; i < 7; i++) begin
            rchk(ra[i], rv[i]);
        end
        check_pins();
        for (int i = 0; i < 8; i++) begin
            cen = 6'($urandom_range(0, 63));
            host = 6'($urandom_range(0, 63));
            wreg(REG_CTRL, 32'(cen));
            wreg(REG_HOST_POWER, 32'(host));
            check_pins();
        end
        cen = 6'h3f;
        for (int s = 0; s < 2; s++) begin
            for (int v = 0; v < 8; v++) begin
                wreg(REG_CTRL, 32'h3f | (32'(s) << CTRL_SPLIT_BIT));
                wreg(REG_SS_ENABLE, 32'(v));
                repeat (3) @(posedge clk);
                chk(32'(ss), (s == 1) ? 32'(v) : 32'h0);
                rchk(REG_SS_ENABLE, 32'(v));
            end
        end
        host = 6'h3f;
        wreg(REG_HOST_POWER, 32'h3f);
        for (int s = 0; s < 2; s++) begin
            wreg(REG_CTRL, 32'h3f | (32'(s) << CTRL_SPLIT_BIT));
            repeat (BLANK + 8) @(posedge clk);
            for (int k = 0; k < NPORTS; k++) begin
                oc_hit(k, s);
            end
        end
        // A low pin on a switched-off port is not an overcurrent
        host = 6'h3e;
        wreg(REG_HOST_POWER, 32'(host));
        repeat (3) @(posedge clk);
        fault <= 6'h01;
        repeat (6) @(posedge clk);
        #1;
        chk(32'(oc_usb2), 32'h0);
        rchk(REG_INT_STATUS, 32'h0);
        check_pins();
        report_and_stop();
    end

endmodule : test_port_power_overcurrent_ctl

bind port_power_oc_ctl port_power_oc_ctl_checker #(.BLANK_CYCLES(BLANK_CYCLES)) i_chk (
    .clk(clk), .rstn(rstn), .wr(wr),
    .port1_power_oc_pin_in(port1_power_oc_pin_in), .port2_power_oc_pin_in(port2_power_oc_pin_in),
    .port3_power_oc_pin_in(port3_power_oc_pin_in), .port4_power_oc_pin_in(port4_power_oc_pin_in),
    .port5_power_oc_pin_in(port5_power_oc_pin_in), .port6_power_oc_pin_in(port6_power_oc_pin_in),
    .port1_power_oc_pin(port1_power_oc_pin), .port2_power_oc_pin(port2_power_oc_pin),
    .port3_power_oc_pin(port3_power_oc_pin), .port4_power_oc_pin(port4_power_oc_pin),
    .port5_power_oc_pin(port5_power_oc_pin), .port6_power_oc_pin(port6_power_oc_pin),
    .port3_superspeed_enable(port3_superspeed_enable),
    .port4_superspeed_enable(port4_superspeed_enable),
    .port5_superspeed_enable(port5_superspeed_enable),
    .oc_event(oc_event), .oc_usb2(oc_usb2), .oc_usb3(oc_usb3));

`default_nettype wire
